/* File: ifep_pkg.sv */
// package: register map, field layout and reset values of the interrupt block
package ifep_pkg;
   // ==========================================================
   // register byte offsets (one aligned word each)
   localparam logic [7:0] IFEP_OFS_PENDING = 8'h00;
   localparam logic [7:0] IFEP_OFS_ENABLE = 8'h04;
   localparam logic [7:0] IFEP_OFS_PRIO = 8'h08;
   localparam logic [7:0] IFEP_OFS_RELOAD = 8'h0C;
   localparam logic [7:0] IFEP_OFS_STATUS = 8'h10;
   localparam logic [7:0] IFEP_OFS_MASK = 8'h14;
   localparam logic [7:0] IFEP_OFS_REQ = 8'h18;
   // ==========================================================
   // priority word layout: slot n priority at 8n+4..8n+2, sub at 8n+1..8n
   localparam int IFEP_SLOTS = 4;
   localparam int IFEP_SLOT_STRIDE = 8;
   localparam int IFEP_PRI_LSB = 2;
   localparam int IFEP_PRI_W = 3;
   localparam int IFEP_SUB_W = 2;
   localparam logic [31:0] IFEP_PRIO_MASK = 32'h1F1F1F1F;
   // ==========================================================
   // reset values
   localparam logic [31:0] IFEP_RST_WORD = 32'h00000000;
   localparam logic [2:0] IFEP_PRI_OFF = 3'h0;
   // status bits: new pending flag, proximity timer load
   localparam int IFEP_ST_PEND = 0;
   localparam int IFEP_ST_LOAD = 1;
   localparam int IFEP_ST_W = 2;
   // bus slave states
   typedef enum logic [0:0] {IFEP_IDLE, IFEP_DONE} ifep_bus_e;
endpackage : ifep_pkg

/* File: ifep_arb_if.sv */
// interface: per-source state handed to the priority arbiter
`timescale 1ns/1ps
interface ifep_arb_if;
   logic [31:0] pending;
   logic [31:0] enable;
   logic [31:0] prioWord;
   logic reqValid;
   logic [4:0] reqSource;
   logic [2:0] reqPriority;
   logic [1:0] reqSubpriority;
   modport ctrl (output pending, output enable, output prioWord,
                 input reqValid, input reqSource, input reqPriority,
                 input reqSubpriority);
   modport arb (input pending, input enable, input prioWord,
                output reqValid, output reqSource, output reqPriority,
                output reqSubpriority);
endinterface : ifep_arb_if

/* File: ifep_arbiter.sv */
// module: picks the highest priority, then subpriority, live source
`timescale 1ns/1ps
module ifep_arbiter
   import ifep_pkg::*;
(
   ifep_arb_if.arb arb
);
   // ==========================================================
   // candidate scan
   logic [4:0] bestSrc;
   logic [2:0] bestPri;
   logic [1:0] bestSub;
   logic found;
   logic [2:0] pri;
   logic [1:0] sub;
   logic [4:0] idx;
   logic [4:0] slotBase;
   // a source maps to one slot of the single word: index mod 4
   always_comb begin
      bestSrc = '0;
      bestPri = IFEP_PRI_OFF;
      bestSub = '0;
      found = 1'b0;
      pri = '0;
      sub = '0;
      idx = '0;
      slotBase = '0;
      for (int i = 0; i < 32; i++) begin
         idx = 5'(i);
         slotBase = 5'((i % IFEP_SLOTS) * IFEP_SLOT_STRIDE);
         pri = arb.prioWord[slotBase + 5'(IFEP_PRI_LSB) +: IFEP_PRI_W];
         sub = arb.prioWord[slotBase +: IFEP_SUB_W];
         if (arb.pending[i] && arb.enable[i] && pri != IFEP_PRI_OFF) begin
            if (!found || pri > bestPri ||
                (pri == bestPri && sub > bestSub)) begin
               found = 1'b1;
               bestSrc = idx;
               bestPri = pri;
               bestSub = sub;
            end
         end
      end
   end
   assign arb.reqValid = found;
   assign arb.reqSource = bestSrc;
   assign arb.reqPriority = bestPri;
   assign arb.reqSubpriority = bestSub;
endmodule : ifep_arbiter

/* File: ifep_ctrl.sv */
// module: interrupt flag, enable and priority registers on Avalon-MM
// Operation
// - an interrupt event loads the proximity timer from the 32-bit reload
// - the pending word holds 32 one-bit flags, bits 31 to 0
// - pending flag 1 means its source requested, 0 means none
// - enable word has 32 bits; 1 enables a source, 0 disables
// - priority 001..111 are levels 1..7; 000 disables the source
// - subpriority 00..11 are levels 0..3
// - slot 3 uses bits 28-26 and 25-24; slot 2 uses 20-18, 17-16
// - slot 1 uses bits 12-10 and 9-8; slot 0 uses 4-2, 1-0
// - bits 31-29, 23-21, 15-13, 7-5 read zero and ignore writes
`timescale 1ns/1ps
module ifep_ctrl
   import ifep_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   input wire logic [31:0] sourceEvent,
   output logic coreRequest,
   output logic [4:0] coreSource,
   output logic [2:0] corePriority,
   output logic [1:0] coreSubpriority,
   output logic timerLoad,
   output logic [31:0] timerLoadValue,
   output logic irq
);
   // ==========================================================
   // elaboration check
   if (ADDR_W < 8) begin : g_badAddr
      $error("ADDR_W must be at least 8");
   end

   // ==========================================================
   // declarations
   ifep_arb_if arbBus ();
   ifep_bus_e busState_r;
   logic [31:0] pending_r;
   logic [31:0] enable_r;
   logic [31:0] prioWord_r;
   logic [31:0] reloadValue_r;
   logic [IFEP_ST_W-1:0] status_r;
   logic [IFEP_ST_W-1:0] mask_r;
   logic [31:0] readdata_r;
   logic [1:0] response_r;
   logic timerLoad_r;
   logic [31:0] timerLoadValue_r;
   logic [31:0] byteMask;
   logic [31:0] readMux;
   logic readHit;
   logic wrTake;
   logic wrReq;
   logic rdTake;
   logic [7:0] ofs;
   logic [IFEP_ST_W-1:0] stEvents;

   // ==========================================================
   // bus slave: request taken in idle, answered one cycle later; a write
   // commits on the answer edge, the only edge the master treats as done
   assign ofs = address[7:0];
   assign wrReq = write && busState_r == IFEP_IDLE;
   assign wrTake = write && busState_r == IFEP_DONE;
   assign rdTake = read && busState_r == IFEP_IDLE;
   // waitrequest low only in the done cycle, so every access takes two edges
   assign waitrequest = !(busState_r == IFEP_DONE);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busState_r <= IFEP_IDLE;
      end else begin
         case (busState_r)
            IFEP_IDLE: begin
               if (read || write) begin
                  busState_r <= IFEP_DONE;
               end
            end
            IFEP_DONE: begin
               busState_r <= IFEP_IDLE;
            end
            default: begin
               busState_r <= IFEP_IDLE;
            end
         endcase
      end
   end

   // byte enables widen to a bit mask
   for (genvar b = 0; b < 4; b++) begin : g_bytes
      assign byteMask[b*8 +: 8] = {8{byteenable[b]}};
   end

   // ==========================================================
   // pending flags: source events set, software writes of 0 clear
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pending_r <= IFEP_RST_WORD;
      end else begin
         if (wrTake && ofs == IFEP_OFS_PENDING) begin
            pending_r <= ((pending_r & ~byteMask) |
                          (writedata & byteMask)) | sourceEvent;
         end else begin
            pending_r <= pending_r | sourceEvent;
         end
      end
   end

   // ==========================================================
   // enables, priority slots and reload value
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enable_r <= IFEP_RST_WORD;
         prioWord_r <= IFEP_RST_WORD;
         reloadValue_r <= IFEP_RST_WORD;
         mask_r <= '0;
      end else if (wrTake) begin
         if (ofs == IFEP_OFS_ENABLE) begin
            enable_r <= (enable_r & ~byteMask) | (writedata & byteMask);
         end else if (ofs == IFEP_OFS_PRIO) begin
            prioWord_r <= ((prioWord_r & ~byteMask) |
                           (writedata & byteMask)) & IFEP_PRIO_MASK;
         end else if (ofs == IFEP_OFS_RELOAD) begin
            reloadValue_r <= (reloadValue_r & ~byteMask) |
                             (writedata & byteMask);
         end else if (ofs == IFEP_OFS_MASK) begin
            mask_r <= writedata[IFEP_ST_W-1:0];
         end
      end
   end

   // ==========================================================
   // proximity timer load on any interrupt event
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timerLoad_r <= 1'b0;
         timerLoadValue_r <= IFEP_RST_WORD;
      end else begin
         timerLoad_r <= |sourceEvent;
         if (|sourceEvent) begin
            timerLoadValue_r <= reloadValue_r;
         end
      end
   end
   assign timerLoad = timerLoad_r;
   assign timerLoadValue = timerLoadValue_r;

   // ==========================================================
   // sticky status, write one to clear; a new event wins the cycle
   assign stEvents[IFEP_ST_PEND] = |(sourceEvent & ~pending_r);
   assign stEvents[IFEP_ST_LOAD] = |sourceEvent;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         status_r <= '0;
      end else if (wrTake && ofs == IFEP_OFS_STATUS) begin
         status_r <= (status_r & ~writedata[IFEP_ST_W-1:0]) | stEvents;
      end else begin
         status_r <= status_r | stEvents;
      end
   end
   assign irq = |(status_r & mask_r);

   // ==========================================================
   // arbitration toward the core
   assign arbBus.pending = pending_r;
   assign arbBus.enable = enable_r;
   assign arbBus.prioWord = prioWord_r;

   ifep_arbiter u_arbiter (
      .arb(arbBus.arb)
   );

   assign coreRequest = arbBus.reqValid;
   assign coreSource = arbBus.reqSource;
   assign corePriority = arbBus.reqPriority;
   assign coreSubpriority = arbBus.reqSubpriority;

   // ==========================================================
   // read decode; unmapped offsets read zero with a slave error
   always_comb begin
      readMux = '0;
      readHit = 1'b1;
      if (ofs == IFEP_OFS_PENDING) begin
         readMux = pending_r;
      end else if (ofs == IFEP_OFS_ENABLE) begin
         readMux = enable_r;
      end else if (ofs == IFEP_OFS_PRIO) begin
         readMux = prioWord_r & IFEP_PRIO_MASK;
      end else if (ofs == IFEP_OFS_RELOAD) begin
         readMux = reloadValue_r;
      end else if (ofs == IFEP_OFS_STATUS) begin
         readMux = {{(32-IFEP_ST_W){1'b0}}, status_r};
      end else if (ofs == IFEP_OFS_MASK) begin
         readMux = {{(32-IFEP_ST_W){1'b0}}, mask_r};
      end else if (ofs == IFEP_OFS_REQ) begin
         readMux = {21'h0, arbBus.reqValid, arbBus.reqSubpriority,
                    arbBus.reqPriority, arbBus.reqSource};
      end else begin
         readHit = 1'b0;
      end
   end

   // read data and response registered for the answer cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         readdata_r <= IFEP_RST_WORD;
         response_r <= 2'h0;
      end else if (rdTake || wrReq) begin
         readdata_r <= rdTake ? readMux : IFEP_RST_WORD;
         response_r <= readHit ? 2'h0 : 2'h2;
      end
   end
   assign readdata = readdata_r;
   assign response = response_r;
endmodule : ifep_ctrl

/* File: ifep_ctrl_asserts.sv */
// checker: concurrent assertions on the interrupt block's ports
`timescale 1ns/1ps
module ifep_ctrl_asserts
   import ifep_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   input wire logic [31:0] sourceEvent,
   input wire logic coreRequest,
   input wire logic [2:0] corePriority,
   input wire logic timerLoad
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ==========================================
   // bus handshake: one idle cycle, then a single answer cycle
   a_wait_answer:
      assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer one cycle after a taken request");
   a_wait_release:
      assert property (!waitrequest |=> waitrequest)
      else $error("answer cycle longer than one cycle");
   a_unmapped_err:
      assert property (read && !waitrequest && address == 8'h1C
                       |-> response == 2'h2 && readdata == 32'h0)
      else $error("unmapped read not refused");
   a_reset_idle:
      assert property ($rose(nrst) |-> waitrequest && !timerLoad)
      else $error("bus or timer load active right after reset");
   // ==========================================
   // register and event behaviour
   a_prio_gaps:
      assert property (read && !waitrequest && address == IFEP_OFS_PRIO
                       |-> (readdata & ~IFEP_PRIO_MASK) == 32'h0)
      else $error("unused priority word bits read nonzero");
   a_load_pulse:
      assert property (|sourceEvent |=> timerLoad)
      else $error("event did not load the proximity timer");
   a_load_quiet:
      assert property (!(|sourceEvent) |=> !timerLoad)
      else $error("timer load without an event");
   a_req_prio:
      assert property (coreRequest |-> corePriority != IFEP_PRI_OFF)
      else $error("request raised at priority zero");
endmodule : ifep_ctrl_asserts

bind ifep_ctrl ifep_ctrl_asserts #(.ADDR_W(ADDR_W)) ifep_ctrl_asserts_i (
   .mclk(mclk), .nrst(nrst), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .response(response), .sourceEvent(sourceEvent),
   .coreRequest(coreRequest), .corePriority(corePriority),
   .timerLoad(timerLoad));

/* File: ifep_core_model.sv */
// partner model: core that takes the offered request after a set lag
`timescale 1ns/1ps
module ifep_core_model
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic coreRequest,
   input wire logic [4:0] coreSource,
   input wire logic [3:0] lag,
   output logic [4:0] takenSrc
);
   logic [3:0] held_r;
   // ==========================================
   // a slow core lets the request stand lag cycles before taking it
   // only an asserted request is taken
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         held_r <= 4'h0;
         takenSrc <= 5'h1F;
      end else if (!coreRequest) begin
         held_r <= 4'h0;
      end else if (held_r < lag) begin
         held_r <= held_r + 4'h1;
      end else begin
         takenSrc <= coreSource;
      end
   end
endmodule : ifep_core_model

/* File: tb_ifep_ctrl.sv */
// testbench: register, priority, event and interrupt tests
`timescale 1ns/1ps
module tb_ifep_ctrl
   import ifep_pkg::*;
;
   logic mclk, nrst, read, write, waitrequest, coreRequest, timerLoad, irq;
   logic [7:0] address;
   logic [31:0] writedata, readdata, sourceEvent, timerLoadValue;
   logic [3:0] byteenable, lag;
   logic [1:0] response, coreSubpriority;
   logic [4:0] coreSource, takenSrc;
   logic [2:0] corePriority;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   ifep_ctrl ifep_ctrl_i (.mclk(mclk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response),
      .sourceEvent(sourceEvent), .coreRequest(coreRequest),
      .coreSource(coreSource), .corePriority(corePriority),
      .coreSubpriority(coreSubpriority), .timerLoad(timerLoad),
      .timerLoadValue(timerLoadValue), .irq(irq));
   ifep_core_model ifep_core_model_i (.mclk(mclk), .nrst(nrst),
      .coreRequest(coreRequest), .coreSource(coreSource), .lag(lag),
      .takenSrc(takenSrc));
   // ==========================================
   // clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   // ==========================================
   // tasks: signals read right after an edge still hold pre-edge values
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge mclk);
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      address <= a;
      read <= 1'b1;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      chk(readdata, e);
      read <= 1'b0;
      @(posedge mclk);
   endtask : bus_rd
   task automatic fire(input logic [31:0] v);
      sourceEvent <= v;
      @(posedge mclk);
      sourceEvent <= 32'h0;
      @(posedge mclk);
   endtask : fire
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // ==========================================
   // main sequence
   initial begin
      {nrst, read, write, address, writedata} = '0;
      byteenable = 4'hF;
      sourceEvent = 32'h0;
      lag = 4'h0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      for (int a = 0; a < 16; a += 4) bus_rd(8'(a), 32'h0);
      bus_wr(IFEP_OFS_PRIO, 32'hFFFFFFFF);
      bus_rd(IFEP_OFS_PRIO, 32'h1F1F1F1F);
      bus_wr(IFEP_OFS_ENABLE, 32'hA5A5A5A5);
      bus_rd(IFEP_OFS_ENABLE, 32'hA5A5A5A5);
      bus_rd(8'h1C, 32'h0);
      chk(response, 2'h2);
      $display("register test done");
      bus_wr(IFEP_OFS_ENABLE, 32'h0000000F);
      bus_wr(IFEP_OFS_PRIO, 32'h15160F00);
      fire(32'h1);
      chk(coreRequest, 1'b0);
      fire(32'h2);
      chk({coreSource, corePriority, coreSubpriority}, 10'h02F);
      fire(32'h8);
      chk({coreSource, corePriority, coreSubpriority}, 10'h075);
      fire(32'h4);
      chk({coreSource, coreSubpriority}, 7'h0A);
      bus_rd(IFEP_OFS_PENDING, 32'h0000000F);
      repeat (2) @(posedge mclk);
      chk(takenSrc, 5'h02);
      bus_wr(IFEP_OFS_ENABLE, 32'h0);
      chk(coreRequest, 1'b0);
      lag <= 4'h3;
      bus_wr(IFEP_OFS_PENDING, 32'h0000000B);
      bus_rd(IFEP_OFS_PENDING, 32'h0000000B);
      bus_wr(IFEP_OFS_ENABLE, 32'h0000000F);
      repeat (6) @(posedge mclk);
      chk(takenSrc, 5'h03);
      $display("priority test done");
      bus_wr(IFEP_OFS_RELOAD, 32'hDEADBEEF);
      fire(32'h80000000);
      chk(timerLoad, 1'b1);
      chk(timerLoadValue, 32'hDEADBEEF);
      bus_rd(IFEP_OFS_PENDING, 32'h8000000B);
      bus_wr(IFEP_OFS_STATUS, 32'h3);
      chk(irq, 1'b0);
      fire(32'h10);
      bus_rd(IFEP_OFS_STATUS, 32'h3);
      chk(irq, 1'b0);
      bus_wr(IFEP_OFS_MASK, 32'h1);
      chk(irq, 1'b1);
      bus_wr(IFEP_OFS_STATUS, 32'h1);
      chk(irq, 1'b0);
      $display("event test done");
      final_report();
   end
endmodule : tb_ifep_ctrl
